// File: logic/shift_latch_map.svh
// Constants for the serial-in, parallel-out shift latch
// Function
// - Shift one stage per shift clock rise
// - Clear low holds stages in reset
// - Serial input enters first stage on rise
// - Serial output low during and after reset
// - Latch clock rise copies stages to output
// - 18-bit parallel output, high-Z after reset
`ifndef SHIFT_LATCH_MAP_SVH
`define SHIFT_LATCH_MAP_SVH

`define STAGE_COUNT 18
`define STAGE_MSB 17
`define STAGE_RESET 18'h00000
`define WORD_RESET 18'h00000
`define DRIVE_OFF 18'h00000
`define DRIVE_ON 18'h3FFFF
`define SERIAL_OUT_RESET 1'h0
`define EDGE_HIST_RESET 2'h0
`define EDGE_RISE 2'h1
`define SYNC_STAGES 2
`define SERIAL_IN_RESET 1'h0
`define WARM_RESET 3'h0
`define WARM_STEP 3'h1
`define WARM_DONE 3'h4

`endif

// File: logic/shift_latch_pkg.sv
// Types shared by the shift latch, its checks and its bench
`default_nettype none
`include "shift_latch_map.svh"

package shift_latch_pkg;

	typedef logic [`STAGE_MSB:0] stage_word_t;

	// Controller-side pins, sampled together
	typedef struct packed {
		logic shift_clock;
		logic shift_clear_n;
		logic serial_bit;
		logic latch_clock;
	} pin_in_s;

	// Three-state parallel output as seen at the pins
	typedef struct packed {
		stage_word_t value;
		stage_word_t drive_en;
	} parallel_out_s;

	typedef enum logic [0:0] {
		OUT_HIGH_Z,
		OUT_DRIVING
	} out_state_e;

endpackage

`default_nettype wire

// File: logic/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Pins in, synchronised levels out
	input wire logic [WIDTH-1:0] async_in,
	output var logic [WIDTH-1:0] sync_out
);

	// First stage feeds only the second one
	logic [WIDTH-1:0] meta;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire

// File: logic/shift_latch.sv
// Serial-in, parallel-out shift register with output latch
`timescale 1ns/1ps
`default_nettype none
`include "shift_latch_map.svh"

module shift_latch
(
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Controller pins
	input wire logic shift_clock_in,
	input wire logic shift_clear_n,
	input wire logic serial_bit_in,
	input wire logic latch_clock_in,
	// Cascade output
	output var logic serial_bit_out,
	// Three-state parallel output
	output var shift_latch_pkg::stage_word_t parallel_word_out,
	output var shift_latch_pkg::stage_word_t parallel_word_oe
);

	import shift_latch_pkg::*;

	pin_in_s pins_raw;
	pin_in_s pins;
	logic [1:0] shift_hist;
	logic [1:0] latch_hist;
	logic shift_rise;
	logic latch_rise;
	stage_word_t stages;
	stage_word_t next_stages;
	parallel_out_s par;
	out_state_e out_state;
	out_state_e next_out_state;

	assign pins_raw.shift_clock = shift_clock_in;
	assign pins_raw.shift_clear_n = shift_clear_n;
	assign pins_raw.serial_bit = serial_bit_in;
	assign pins_raw.latch_clock = latch_clock_in;

	// All four pins share one delay, so data stays aligned with its clock
	pin_sync #(
		.WIDTH($bits(pin_in_s))
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	// Edge history of the synchronised clocks
	// Both clocks share one delay, so their order survives
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_hist <= `EDGE_HIST_RESET;
			latch_hist <= `EDGE_HIST_RESET;
		end
		else
		begin
			shift_hist <= {shift_hist[0], pins.shift_clock};
			latch_hist <= {latch_hist[0], pins.latch_clock};
		end
	end

	// Sync flops read low until filled; a clock pin idling
	// high on its pull-up would fake an edge after reset.
	// Edges count only once the history holds real samples,
	// at the cost of a few dead cycles after reset.
	logic [2:0] warm_count;
	logic hist_valid;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			warm_count <= `WARM_RESET;
		end
		else if (warm_count != `WARM_DONE)
		begin
			warm_count <= warm_count + `WARM_STEP;
		end
	end

	assign hist_valid = (warm_count == `WARM_DONE);

	assign shift_rise = hist_valid && (shift_hist == `EDGE_RISE);
	assign latch_rise = hist_valid && (latch_hist == `EDGE_RISE);

	// Data delayed one cycle, sampled in the same cycle as the edge shows, same age as the clock
	logic serial_bit_d;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serial_bit_d <= `SERIAL_IN_RESET;
		end
		else
		begin
			serial_bit_d <= pins.serial_bit;
		end
	end

	// Clear wins over a shift edge in the same cycle
	always_comb
	begin
		next_stages = stages;
		if (!pins.shift_clear_n)
		begin
			next_stages = `STAGE_RESET;
		end
		else if (shift_rise)
		begin
			next_stages = {stages[`STAGE_MSB-1:0], serial_bit_d};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stages <= `STAGE_RESET;
		end
		else
		begin
			stages <= next_stages;
		end
	end

	// Cascade output tracks the last stage; zero while cleared
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serial_bit_out <= `SERIAL_OUT_RESET;
		end
		else
		begin
			serial_bit_out <= next_stages[`STAGE_MSB];
		end
	end

	// Output stays high-Z until the first latch after reset or clear
	always_comb
	begin
		next_out_state = out_state;
		case (out_state)
			OUT_HIGH_Z:
			begin
				if (latch_rise && pins.shift_clear_n)
				begin
					next_out_state = OUT_DRIVING;
				end
			end
			OUT_DRIVING:
			begin
				if (!pins.shift_clear_n)
				begin
					next_out_state = OUT_HIGH_Z;
				end
			end
			default:
			begin
				// Unused encoding falls back to high-Z
				next_out_state = OUT_HIGH_Z;
			end
		endcase
	end

	// Drive state; reset and clear both land in high-Z
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_state <= OUT_HIGH_Z;
		end
		else
		begin
			out_state <= next_out_state;
		end
	end

	// Holding register; latch copies the stages as they stand now
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			par.value <= `WORD_RESET;
		end
		else if (latch_rise && pins.shift_clear_n)
		begin
			par.value <= stages;
		end
	end

	// Enable follows next state, so value and drive move together
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			par.drive_en <= `DRIVE_OFF;
		end
		else if (next_out_state == OUT_DRIVING)
		begin
			par.drive_en <= `DRIVE_ON;
		end
		else
		begin
			par.drive_en <= `DRIVE_OFF;
		end
	end

	// Pins see the holding register and its enables
	assign parallel_word_out = par.value;
	assign parallel_word_oe = par.drive_en;

endmodule

`default_nettype wire

// File: verification/shift_latch_sva.sv
// Pin-level checks on the shift latch
`timescale 1ns/1ps
`default_nettype none
module shift_latch_sva
(
	// Clock
	input wire logic sys_clk,
	input wire logic rst_n,
	// Pins
	input wire logic shift_clock_in,
	input wire logic shift_clear_n,
	input wire logic latch_clock_in,
	input wire logic serial_bit_out,
	input wire shift_latch_pkg::stage_word_t parallel_word_out,
	input wire shift_latch_pkg::stage_word_t parallel_word_oe
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	property p_rs; $rose(rst_n) |-> (!serial_bit_out)[*3]; endproperty
	a_rs: assert property (p_rs) else $error("sdo");
	property p_rz; $rose(rst_n) |-> (parallel_word_oe == 18'h00000)[*3]; endproperty
	a_rz: assert property (p_rz) else $error("oe");
	property p_cl; (!shift_clear_n)[*6] |-> !serial_bit_out && parallel_word_oe == 18'h00000; endproperty
	a_cl: assert property (p_cl) else $error("clr");
	property p_lt; $rose(latch_clock_in) && shift_clear_n |-> ##[3:6] parallel_word_oe == 18'h3FFFF; endproperty
	a_lt: assert property (p_lt) else $error("lat");
	property p_sh; (!shift_clock_in && shift_clear_n)[*8] |-> $stable(serial_bit_out); endproperty
	a_sh: assert property (p_sh) else $error("sdo");
	property p_wh; (!latch_clock_in)[*8] |-> $stable(parallel_word_out); endproperty
	a_wh: assert property (p_wh) else $error("word");
	// Output rise needs the pin high three samples back
	property p_sr; $rose(serial_bit_out) |-> $past(shift_clock_in, 3); endproperty
	a_sr: assert property (p_sr) else $error("sft");
endmodule
bind shift_latch shift_latch_sva shift_latch_sva_i (.*);
`default_nettype wire

// File: verification/host.sv
// Controller model for the shift latch pins
`timescale 1ns/1ps
`default_nettype none
module host
(
	// Clock
	input wire logic sys_clk,
	// Pins, data idles at its pull-up level
	output var logic shift_clock_in = 1'b0,
	output var logic shift_clear_n = 1'b1,
	output var logic serial_bit_in = 1'b1,
	output var logic latch_clock_in = 1'b0
);
	// 60 ns low, 65 ns high: 125 ns on falling edges
	task automatic tick(input logic l);
		repeat (12) @(negedge sys_clk);
		shift_clock_in = !l;
		latch_clock_in = l;
		repeat (13) @(negedge sys_clk);
		shift_clock_in = 1'b0;
		latch_clock_in = 1'b0;
	endtask
	task automatic send(input logic [17:0] w, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_bit_in = w[i];
			tick(1'b0);
		end
		serial_bit_in = 1'b1;
	endtask
endmodule
`default_nettype wire

// File: verification/shift_latch_tb.sv
// Bench for the shift latch
`timescale 1ns/1ps
`default_nettype none
module shift_latch_tb;
	import shift_latch_pkg::*;
	localparam stage_word_t W = 18'h2A5C3;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic shift_clock_in, shift_clear_n, serial_bit_in, latch_clock_in, serial_bit_out;
	stage_word_t parallel_word_out, parallel_word_oe;
	int err_count = 0;
	int checked = 0;
	shift_latch shift_latch_i (.*);
	host host_i (.*);
	initial
	begin
		forever #2.5 sys_clk = !sys_clk;
	end
	task automatic chk(input string n, input stage_word_t e, input stage_word_t g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic t_reset;
		chk("sdo", 18'h00000, {17'h0, serial_bit_out});
		chk("oe", 18'h00000, parallel_word_oe);
	endtask
	task automatic t_load;
		host_i.send(W, 18);
		chk("oe", 18'h00000, parallel_word_oe);
		chk("sdo", {17'h0, W[17]}, {17'h0, serial_bit_out});
		host_i.tick(1'b1);
		chk("word", W, parallel_word_out);
		chk("oe", 18'h3FFFF, parallel_word_oe);
		host_i.send(18'h00000, 1);
		chk("sdo", {17'h0, W[16]}, {17'h0, serial_bit_out});
		host_i.tick(1'b1);
		chk("word", {W[16:0], 1'b0}, parallel_word_out);
	endtask
	// Shifts and latch under clear must leave nothing behind
	task automatic t_clear;
		host_i.shift_clear_n = 1'b0;
		host_i.send(18'h3FFFF, 3);
		host_i.tick(1'b1);
		chk("oe", 18'h00000, parallel_word_oe);
		host_i.shift_clear_n = 1'b1;
		host_i.tick(1'b1);
		chk("word", 18'h00000, parallel_word_out);
	endtask
	initial
	begin
		repeat (20) @(negedge sys_clk);
		t_reset;
		rst_n = 1'b1;
		@(negedge sys_clk);
		t_reset;
		t_load;
		t_clear;
		give_verdict;
	end
	initial
	begin
		#100000;
		err_count++;
		give_verdict;
	end
endmodule
`default_nettype wire
